// ---- dv/dout_image_sva.sv ----
/*
  Port assertions of the output image block.
  Bound to every dout_image instance; hready is the slave's own hreadyout.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dout_image_regs.svh"

module dout_image_sva (
    input wire logic                       hclk,
    input wire logic                       hresetn,
    input wire logic                       hsel,
    input wire logic [31:0]                haddr,
    input wire logic [1:0]                 htrans,
    input wire logic                       hwrite,
    input wire logic                       hready,
    input wire logic                       hreadyout,
    input wire logic                       hresp,
    input wire logic [31:0]                hrdata,
    input wire dout_image_pkg::sense_bus_t chan_sense,
    input wire logic [7:0]                 dout,
    input wire logic                       irq
);
    // address phases taken by the slave
    wire logic take = hsel && hready && htrans[1];
    wire logic take_wr = take && hwrite;
    wire logic drive_wr = take_wr && (haddr[7:0] == `OFS_OUT_IMAGE || haddr[7:0] == `OFS_VARIANT);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_okay_only: assert property (hresp == 1'b0)
        else $error("response other than okay");
    chk_write_fast: assert property (take_wr |=> hreadyout)
        else $error("write data phase stalled");
    chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one");
    // read data is loaded at the second edge after the address phase is taken
    chk_rdata_hold: assert property ($changed(hrdata) |-> $past(take && !hwrite, 2))
        else $error("read data moved outside a read");
    // image or variant lands at edge two, the drive flop follows at edge three
    chk_dout_cause: assert property ($changed(dout) |-> $past(drive_wr, 3))
        else $error("drive changed without image write");
    chk_irq_rise: assert property ($rose(irq) |->
        $past(chan_sense, 3) != $past(chan_sense, 4) || $past(take_wr, 2) || $past(take_wr, 3))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property ($fell(irq) |-> $past(take_wr, 2))
        else $error("interrupt fell without write");
    chk_reset_idle: assert property (disable iff (1'b0) !hresetn |-> dout == 8'h00 && !irq && hreadyout)
        else $error("outputs active in reset");
endmodule

bind dout_image dout_image_sva dout_image_sva_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .chan_sense(chan_sense), .dout(dout), .irq(irq)
);

`default_nettype wire

// ---- dv/field_model.sv ----
/*
  Field side of the output channels: fault sense lines as the load would show them.
  Assumes the bench commands faults; lines change only after a clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module field_model (
    input  wire logic                       hclk,
    input  wire dout_image_pkg::sense_bus_t inject,
    output var  dout_image_pkg::sense_bus_t chan_sense
);
    // faults appear on the lines one edge after they are commanded
    always_ff @(posedge hclk) begin
        chan_sense <= inject;
    end
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
/*
  Self-checking bench of the output image block over AHB-Lite.
  Assumes one master, word transfers, and the field model on the sense pins.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dout_image_regs.svh"

module tb_top;
    logic                       hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [1:0]                 htrans;
    logic [2:0]                 hsize;
    logic [31:0]                haddr, hwdata, hrdata;
    logic [7:0]                 dout;
    dout_image_pkg::sense_bus_t chan_sense, inject;
    int                         num_errors, n_checks;

    dout_image dout_image_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chan_sense(chan_sense),
        .dout(dout), .irq(irq));
    field_model field_model_inst (.hclk(hclk), .inject(inject), .chan_sense(chan_sense));

    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // waits for hready high at a rising edge, takes read data at that edge
    task automatic wait_rdy(output logic [31:0] rd);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy(rd);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask

    // sense lines settle through the synchroniser and status flop
    task automatic sense_set(input logic [31:0] v);
        inject <= v;
        repeat (5) @(posedge hclk);
    endtask

    function automatic logic [1:0] code(input int line);
        return line > 1 ? `CODE_SHORT_LO : `CODE_OPEN_HI;
    endfunction

    task automatic t_reset();
        rd_chk(`OFS_OUT_IMAGE, {24'h0, `RST_OUT_IMAGE});
        rd_chk(`OFS_IN_IMAGE, 32'h0);
        rd_chk(`OFS_VARIANT, {29'h0, `RST_VARIANT});
        rd_chk(`OFS_IRQ_STATUS, {24'h0, `RST_IRQ_STATUS});
        rd_chk(`OFS_IRQ_MASK, {24'h0, `RST_IRQ_MASK});
        rd_chk(8'h14, 32'h0);
    endtask

    task automatic t_out8();
        for (int n = 0; n < 8; n++) begin
            wr(`OFS_OUT_IMAGE, 32'h1 << n);
            rd_chk(`OFS_OUT_IMAGE, 32'h1 << n);
            chk({24'h0, dout}, 32'h1 << n);
        end
        wr(`OFS_OUT_IMAGE, 32'hffff_ff5a);
        rd_chk(`OFS_OUT_IMAGE, 32'h5a);
    endtask

    task automatic t_diag8();
        for (int n = 0; n < 8; n++) begin
            sense_set(32'h1 << (4 * n + n % 4));
            rd_chk(`OFS_IN_IMAGE, 32'h1 << n);
        end
        sense_set(32'h0);
        rd_chk(`OFS_IN_IMAGE, 32'h0);
    endtask

    task automatic t_diag4();
        wr(`OFS_VARIANT, 32'h4);
        wr(`OFS_OUT_IMAGE, 32'hff);
        rd_chk(`OFS_OUT_IMAGE, 32'h0f);
        chk({24'h0, dout}, 32'h0f);
        sense_set(32'hffff_ffff);
        rd_chk(`OFS_IN_IMAGE, 32'h0f);
        wr(`OFS_VARIANT, 32'h1);
        rd_chk(`OFS_IN_IMAGE, 32'h03);
        wr(`OFS_VARIANT, 32'h3);
        rd_chk(`OFS_IN_IMAGE, 32'h0);
    endtask

    task automatic t_code2();
        wr(`OFS_VARIANT, 32'h2);
        // the drive flop takes the new channel mask one edge after the write
        repeat (2) @(posedge hclk);
        chk({24'h0, dout}, 32'h03);
        for (int i = 0; i < 4; i++) begin
            sense_set((32'h1 << i) | (32'h10 << (3 - i)));
            rd_chk(`OFS_IN_IMAGE, {28'h0, code(3 - i), code(i)});
        end
        sense_set(32'h9);
        rd_chk(`OFS_IN_IMAGE, {28'h0, `CODE_NORMAL, `CODE_SHORT_LO});
        sense_set(32'h0);
        rd_chk(`OFS_IN_IMAGE, 32'h0);
        // plain variants report nothing, even with every fault line up
        wr(`OFS_VARIANT, {29'h0, `VAR_PLAIN2});
        sense_set(32'hffff_ffff);
        rd_chk(`OFS_IN_IMAGE, 32'h0);
        rd_chk(`OFS_OUT_IMAGE, 32'h03);
        wr(`OFS_VARIANT, {29'h0, `VAR_PLAIN8});
        wr(`OFS_VARIANT, 32'h7);
        rd_chk(`OFS_VARIANT, {29'h0, `VAR_PLAIN8});
        wr(`OFS_OUT_IMAGE, 32'hff);
        rd_chk(`OFS_OUT_IMAGE, 32'hff);
        chk({24'h0, dout}, 32'hff);
        rd_chk(`OFS_IN_IMAGE, 32'h0);
        sense_set(32'h0);
    endtask

    task automatic t_irq();
        wr(`OFS_VARIANT, 32'h6);
        wr(`OFS_IRQ_STATUS, 32'hff);
        wr(`OFS_IRQ_MASK, 32'h1);
        sense_set(32'h10);
        rd_chk(`OFS_IRQ_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h0);
        sense_set(32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h0);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h1);
        rd_chk(`OFS_IRQ_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h0);
    endtask

    // reset in mid-run clears drive and interrupt, then registers read back as after power-up
    task automatic t_reset_mid();
        sense_set(32'h0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({24'h0, dout}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        hresetn <= 1'b1;
        t_reset();
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles needed
    initial begin
        #100us;
        num_errors++;
        end_of_test();
    end

    // reset, then the scenarios in turn
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        inject = '0;
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_out8();
        t_diag8();
        t_diag4();
        t_code2();
        t_irq();
        t_reset_mid();
        end_of_test();
    end
endmodule

`default_nettype wire

// ---- rtl/chan_diag.sv ----
/*
  Fault decode of one output channel: single fault flag and two-bit fault code.
  Assumes synchronised sense lines; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dout_image_regs.svh"

module chan_diag (
    input  wire dout_image_pkg::chan_sense_t sense,
    output logic                           flag,
    output logic [1:0]                     code
);

    // any fault raises the flag; ground short or overload wins the code
    always_comb begin
        flag = sense.overload | sense.short_gnd | sense.open_load | sense.short_vcc;
        if (sense.overload || sense.short_gnd) begin
            code = `CODE_SHORT_LO;
        end else if (sense.open_load || sense.short_vcc) begin
            code = `CODE_OPEN_HI;
        end else begin
            code = `CODE_NORMAL;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/dout_image.sv ----
/*
  Digital output process image with diagnostics, reached over AHB-Lite.
  Holds the output image, variant select, input image, and fault interrupt logic.
  Assumes one AHB-Lite master, word transfers, and asynchronous channel sense pins.
*/
// How it works
// - each output pin follows exactly one output image bit
// - eight channel variants use all eight bits, bit n drives channel n plus one
// - diagnostic variants give every driven channel its own fault flag
// - overload, short circuit or broken wire sets the channel fault flag
// - faults appear only in the input image, control only in the output image
// - single fault flag reads 0 healthy, 1 faulty
// - four channel diagnostic variant: input bits 0 to 3 flag channels 1 to 4
// - two-bit variant gives each channel a two-bit fault code
// - two-bit variant: input bits 1:0 channel 1, bits 3:2 channel 2
// - codes: 00 normal, 01 no load or short high, 10 ground short or overload
`timescale 1ns/100ps
`default_nettype none
`include "dout_image_regs.svh"

module dout_image (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    input  wire dout_image_pkg::sense_bus_t chan_sense,
    output logic [7:0]                    dout,
    output logic                          irq
);

    dout_image_pkg::image_state_t s;
    dout_image_pkg::image_state_t next_s;
    dout_image_pkg::sense_bus_t   sense_q;

    logic [7:0]  flag;
    logic [1:0]  code [0:7];
    logic [7:0]  chan_mask;
    logic        diag_var;
    logic [7:0]  flags_act;
    logic [7:0]  in_image;
    logic [7:0]  rise;
    logic [7:0]  w1c;
    logic        accept;
    logic [31:0] rd_val;

    // sense pins pass two flip-flops before decode
    sense_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pins    (chan_sense),
        .synced  (sense_q)
    );

    // one fault decoder per channel
    genvar gi;
    generate
        for (gi = 0; gi < `CH_COUNT; gi = gi + 1) begin : g_diag
            chan_diag u_diag (
                .sense (sense_q[gi]),
                .flag  (flag[gi]),
                .code  (code[gi])
            );
        end
    endgenerate

    // channel count and diagnostic kind of the selected variant
    always_comb begin
        chan_mask = `MASK_NONE;
        diag_var  = 1'b0;
        case (s.variant)
            `VAR_PLAIN2: begin
                chan_mask = `MASK_2CH;
            end
            `VAR_DIAG2: begin
                chan_mask = `MASK_2CH;
                diag_var  = 1'b1;
            end
            `VAR_CODE2: begin
                chan_mask = `MASK_2CH;
            end
            `VAR_PLAIN4: begin
                chan_mask = `MASK_4CH;
            end
            `VAR_DIAG4: begin
                chan_mask = `MASK_4CH;
                diag_var  = 1'b1;
            end
            `VAR_PLAIN8: begin
                chan_mask = `MASK_8CH;
            end
            `VAR_DIAG8: begin
                chan_mask = `MASK_8CH;
                diag_var  = 1'b1;
            end
            default: begin
                chan_mask = `MASK_NONE;
            end
        endcase
    end

    // fault flags of driven channels; the two-bit variant also raises events
    always_comb begin
        if (diag_var || s.variant == `VAR_CODE2) begin
            flags_act = flag & chan_mask;
        end else begin
            flags_act = `MASK_NONE;
        end
    end

    // input image: flags, codes, or nothing; never carries control bits
    always_comb begin
        if (diag_var) begin
            in_image = flags_act;
        end else if (s.variant == `VAR_CODE2) begin
            in_image = {4'h0, code[1], code[0]};
        end else begin
            in_image = `MASK_NONE;
        end
    end

    // read mux; unused bits and unmapped offsets read zero
    always_comb begin
        case (s.addr)
            `OFS_OUT_IMAGE: begin
                rd_val = {24'h0, s.out_image & chan_mask};
            end
            `OFS_IN_IMAGE: begin
                rd_val = {24'h0, in_image};
            end
            `OFS_VARIANT: begin
                rd_val = {29'h0, s.variant};
            end
            `OFS_IRQ_STATUS: begin
                rd_val = {24'h0, s.irq_status};
            end
            `OFS_IRQ_MASK: begin
                rd_val = {24'h0, s.irq_mask};
            end
            default: begin
                rd_val = `RST_WORD;
            end
        endcase
    end

    // new transfer seen in an address phase
    assign accept = hsel & hready & htrans[`HTRANS_BUSY_BIT];
    assign rise   = flags_act & ~s.fault_prev;

    // next state: bus phases, register writes, events
    always_comb begin
        next_s = s;
        w1c    = `MASK_NONE;

        // data phase work
        case (s.phase)
            dout_image_pkg::PH_WRITE: begin
                case (s.addr)
                    `OFS_OUT_IMAGE: begin
                        next_s.out_image = hwdata[7:0] & chan_mask;
                    end
                    `OFS_VARIANT: begin
                        if (hwdata[2:0] <= `VAR_DIAG8) begin
                            next_s.variant = hwdata[2:0];
                        end
                    end
                    `OFS_IRQ_STATUS: begin
                        w1c = hwdata[7:0];
                    end
                    `OFS_IRQ_MASK: begin
                        next_s.irq_mask = hwdata[7:0];
                    end
                    default: begin
                        w1c = `MASK_NONE;
                    end
                endcase
            end
            dout_image_pkg::PH_READ: begin
                next_s.hrdata = rd_val;
            end
            default: begin
                next_s.hrdata = s.hrdata;
            end
        endcase

        // phase sequencing; a read waits one cycle for its data
        if (s.phase == dout_image_pkg::PH_READ) begin
            next_s.phase = dout_image_pkg::PH_RDONE;
        end else if (accept) begin
            next_s.addr  = haddr[7:0];
            next_s.phase = hwrite ? dout_image_pkg::PH_WRITE : dout_image_pkg::PH_READ;
        end else begin
            next_s.phase = dout_image_pkg::PH_IDLE;
        end

        // sticky fault events; a new event beats a same-cycle clear
        next_s.fault_prev = flags_act;
        next_s.irq_status = (s.irq_status & ~w1c) | rise;

        // each pin from its own image bit only
        next_s.dout = s.out_image & chan_mask;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s.phase      <= dout_image_pkg::PH_IDLE;
            s.addr       <= `OFS_OUT_IMAGE;
            s.out_image  <= `RST_OUT_IMAGE;
            s.variant    <= `RST_VARIANT;
            s.irq_status <= `RST_IRQ_STATUS;
            s.irq_mask   <= `RST_IRQ_MASK;
            s.fault_prev <= `MASK_NONE;
            s.dout       <= `RST_OUT_IMAGE;
            s.hrdata     <= `RST_WORD;
        end else begin
            s <= next_s;
        end
    end

    // outputs
    assign hreadyout = (s.phase != dout_image_pkg::PH_READ);
    assign hresp     = 1'b0;
    assign hrdata    = s.hrdata;
    assign dout      = s.dout;
    assign irq       = |(s.irq_status & s.irq_mask);

endmodule

`default_nettype wire

// ---- rtl/dout_image_pkg.sv ----
/*
  Types shared by the digital output image block: sense inputs, bus phases, state records.
  Assumes the register header is included by the files that need numeric constants.
*/
package dout_image_pkg;

    // raw fault sense lines of one output channel
    typedef struct packed {
        logic overload;
        logic short_gnd;
        logic open_load;
        logic short_vcc;
    } chan_sense_t;

    typedef chan_sense_t [7:0] sense_bus_t;

    // ahb slave phase, one-hot
    typedef enum logic [3:0] {
        PH_IDLE  = 4'h1,
        PH_WRITE = 4'h2,
        PH_READ  = 4'h4,
        PH_RDONE = 4'h8
    } bus_phase_t;

    // whole state of the top module
    typedef struct packed {
        bus_phase_t  phase;
        logic [7:0]  addr;
        logic [7:0]  out_image;
        logic [2:0]  variant;
        logic [7:0]  irq_status;
        logic [7:0]  irq_mask;
        logic [7:0]  fault_prev;
        logic [7:0]  dout;
        logic [31:0] hrdata;
    } image_state_t;

    // two-stage synchroniser state
    typedef struct packed {
        sense_bus_t meta;
        sense_bus_t held;
    } sync_state_t;

endpackage

// ---- rtl/dout_image_regs.svh ----
/*
  Register offsets, field codes and reset values of the digital output image block.
  Assumes the includer compares offsets against the low byte of the AHB address.
*/
`ifndef DOUT_IMAGE_REGS_SVH
`define DOUT_IMAGE_REGS_SVH

// register byte offsets
`define OFS_OUT_IMAGE   8'h00
`define OFS_IN_IMAGE    8'h04
`define OFS_VARIANT     8'h08
`define OFS_IRQ_STATUS  8'h0c
`define OFS_IRQ_MASK    8'h10

// module variant codes held in the variant register
`define VAR_PLAIN2      3'h0
`define VAR_DIAG2       3'h1
`define VAR_CODE2       3'h2
`define VAR_PLAIN4      3'h3
`define VAR_DIAG4       3'h4
`define VAR_PLAIN8      3'h5
`define VAR_DIAG8       3'h6

// channel masks per channel count
`define MASK_NONE       8'h00
`define MASK_2CH        8'h03
`define MASK_4CH        8'h0f
`define MASK_8CH        8'hff

// two-bit fault codes
`define CODE_NORMAL     2'h0
`define CODE_OPEN_HI    2'h1
`define CODE_SHORT_LO   2'h2

// reset values
`define RST_OUT_IMAGE   8'h00
`define RST_VARIANT     3'h6
`define RST_IRQ_MASK    8'h00
`define RST_IRQ_STATUS  8'h00
`define RST_WORD        32'h0000_0000

// channel count and ahb transfer type bit
`define CH_COUNT        8
`define HTRANS_BUSY_BIT 1

`endif

// ---- rtl/sense_sync.sv ----
/*
  Two flip-flop synchroniser for all channel sense pins.
  Assumes the pins are asynchronous to hclk; only the second stage is read outside.
*/
`timescale 1ns/100ps
`default_nettype none

module sense_sync (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire dout_image_pkg::sense_bus_t pins,
    output var  dout_image_pkg::sense_bus_t synced
);

    dout_image_pkg::sync_state_t s;
    dout_image_pkg::sync_state_t next_s;

    // shift pins through two stages
    always_comb begin
        next_s      = s;
        next_s.meta = pins;
        next_s.held = s.meta;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign synced = s.held;

endmodule

`default_nettype wire
